// ==== ars_receiver.sv ====
// receive sampler: start detection, three-sample voting, double-buffered data and flags
// Operation
// - eight data bits per frame unless the nine-bit width is selected
// - after the stop bit, move character to empty buffer and set full flag
// - character completing while full sets overrun and is dropped
// - shifter plus buffer give software one character time to read
// - status read then data read clears the full flag and other flags
// - sample input on sixteen slots per bit from a 16x tick
// - falling edge is a low sample after three high samples
// - start accepted only if two of slots 3, 5, 7 are low
// - every data and stop bit valued by majority of slots 8, 9, 10
// - qualified start bit counts as zero whatever its mid samples show
// - any sample disagreeing with its bit sets noise on transfer
// - falling edges after the start bit realign the slot timing
// - after non-break framing error, edge history preloads three highs
// - while framing flag set, shifter runs but nothing is transferred
// - wakeup standby ignores characters meant for other receivers
`timescale 1ns/100ps
`include "ars_params.svh"
module ars_receiver (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SAMPLE_TICK,
	input wire logic RXD_IN,
	input wire logic DATA9_SEL,
	input wire logic WAKE_REQ,
	input wire logic STATUS_RD,
	input wire logic DATA_RD,
	output logic [8:0] RX_DATA,
	output ars_pkg::ars_status_t RX_STATUS,
	output logic RX_STANDBY
);
	logic rst_a_q;
	logic rst_n_s;
	ars_pkg::ars_state_t state_q;
	logic [3:0] slot_q;
	logic [3:0] bit_idx_q;
	logic [2:0] hist_q;
	logic [1:0] low_cnt_q;
	logic early_high_q;
	logic [1:0] mid_q;
	logic noise_acc_q;
	logic [8:0] shift_q;
	logic arm_q;
	ars_pkg::ars_status_t st_q;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_a_q <= 1'b0;
			rst_n_s <= 1'b0;
		end
		else
		begin
			rst_a_q <= 1'b1;
			rst_n_s <= rst_a_q;
		end
	end

	wire [3:0] nbits = DATA9_SEL ? `ARS_DATA_BITS_ALT : `ARS_DATA_BITS_STD;
	wire edge_det = SAMPLE_TICK && (hist_q == `ARS_HIST_IDLE) && !RXD_IN;
	wire at_early = (slot_q == `ARS_SLOT_RT3) || (slot_q == `ARS_SLOT_RT5) || (slot_q == `ARS_SLOT_RT7);
	wire at_mid = (slot_q == `ARS_SLOT_RT8) || (slot_q == `ARS_SLOT_RT9);
	wire at_vote = slot_q == `ARS_SLOT_RT10;
	wire [1:0] low_total = low_cnt_q + {1'b0, !RXD_IN};
	wire maj = (mid_q[0] & mid_q[1]) | (mid_q[0] & RXD_IN) | (mid_q[1] & RXD_IN);
	wire disagree = (mid_q[0] != maj) || (mid_q[1] != maj) || (RXD_IN != maj);
	wire in_bits = SAMPLE_TICK && (state_q == ars_pkg::ARS_BITS);
	wire done = in_bits && at_vote && (bit_idx_q == nbits);
	wire [8:0] word = DATA9_SEL ? shift_q : {1'b0, shift_q[8:1]};
	wire frame_noise = noise_acc_q | disagree;
	wire is_break = (word == `ARS_WORD_RESET) && !maj;
	wire wake_hit = DATA9_SEL ? word[8] : word[7];
	// standby drops characters up to and including an address-marked one
	wire accept = done && !RX_STANDBY && !st_q.framing;
	wire clr = arm_q && DATA_RD;
	wire load = accept && (!st_q.full || clr);

	always_ff @(posedge CLK or negedge rst_n_s)
	begin
		if (!rst_n_s)
			hist_q <= `ARS_HIST_IDLE;
		else if (done && !maj && !is_break)
			hist_q <= `ARS_HIST_IDLE;
		else if (SAMPLE_TICK)
			hist_q <= {hist_q[1:0], RXD_IN};
	end

	always_ff @(posedge CLK or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			state_q <= ars_pkg::ARS_IDLE;
			slot_q <= 4'h0;
			bit_idx_q <= 4'h0;
			low_cnt_q <= 2'h0;
			early_high_q <= 1'b0;
			mid_q <= 2'h0;
			noise_acc_q <= 1'b0;
			shift_q <= `ARS_WORD_RESET;
		end
		else if (SAMPLE_TICK)
		begin
			case (state_q)
				ars_pkg::ARS_IDLE:
				begin
					if (edge_det)
					begin
						state_q <= ars_pkg::ARS_START;
						slot_q <= 4'h1;
						low_cnt_q <= 2'h0;
						early_high_q <= 1'b0;
						noise_acc_q <= 1'b0;
						bit_idx_q <= 4'h0;
					end
				end
				ars_pkg::ARS_START:
				begin
					slot_q <= slot_q + 4'h1;
					if (at_early)
					begin
						low_cnt_q <= low_total;
						early_high_q <= early_high_q | RXD_IN;
					end
					if (at_mid)
						mid_q <= {mid_q[0], RXD_IN};
					if ((slot_q == `ARS_SLOT_RT7) && (low_total < `ARS_MIN_LOW_VOTES))
						state_q <= ars_pkg::ARS_IDLE;
					// start taken as zero; any high sample is noise
					if (at_vote)
						noise_acc_q <= early_high_q | mid_q[0] | mid_q[1] | RXD_IN;
					if (slot_q == `ARS_SLOT_RT16)
						state_q <= ars_pkg::ARS_BITS;
				end
				ars_pkg::ARS_BITS:
				begin
					// realign on every falling edge in the data and stop bits
					slot_q <= edge_det ? 4'h1 : slot_q + 4'h1;
					if (at_mid)
						mid_q <= {mid_q[0], RXD_IN};
					if (at_vote)
					begin
						noise_acc_q <= frame_noise;
						// shifter keeps running regardless of flags
						if (bit_idx_q != nbits)
						begin
							shift_q <= {maj, shift_q[8:1]};
							bit_idx_q <= bit_idx_q + 4'h1;
						end
						else
							state_q <= ars_pkg::ARS_IDLE;
					end
				end
				default:
					state_q <= ars_pkg::ARS_IDLE;
			endcase
		end
	end

	// two-step clear: status read arms, data read clears
	always_ff @(posedge CLK or negedge rst_n_s)
	begin
		if (!rst_n_s)
			arm_q <= 1'b0;
		else if (DATA_RD)
			arm_q <= 1'b0;
		else if (STATUS_RD && (st_q != 4'h0))
			arm_q <= 1'b1;
	end

	// set wins over the clear in the same cycle for full, noise and framing; overrun is cleared, its set needs no clear
	always_ff @(posedge CLK or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			st_q <= 4'h0;
			RX_STANDBY <= 1'b0;
		end
		else
		begin
			st_q.full <= load | (st_q.full & !clr);
			st_q.overrun <= (accept & st_q.full & !clr) | (st_q.overrun & !clr);
			st_q.noise <= (load & frame_noise) | (st_q.noise & !clr);
			st_q.framing <= (accept & !maj) | (st_q.framing & !clr);
			if (WAKE_REQ)
				RX_STANDBY <= 1'b1;
			else if (done && RX_STANDBY && wake_hit)
				RX_STANDBY <= 1'b0;
		end
	end

	assign RX_STATUS = st_q;

	// separate buffer register frees the shifter for the next frame
	ars_rx_buffer #(
		.W(9)
	) u_buf (
		.clk(CLK),
		.rst_n(rst_n_s),
		.load(load),
		.wdata(word),
		.rdata(RX_DATA)
	);

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!rst_n_s);

	full_on_load_a: assert property (load |=> st_q.full && (RX_DATA == $past(word)))
		else $error("full flag or data missing after transfer");
	overrun_keep_a: assert property (accept && st_q.full && !clr |=> st_q.overrun && $stable(RX_DATA))
		else $error("overrun not flagged or buffer overwritten");
	clear_seq_a: assert property (STATUS_RD && st_q.full && !DATA_RD ##1 DATA_RD && !load |=> !st_q.full)
		else $error("two-step clear failed");
	edge_start_a: assert property (state_q == ars_pkg::ARS_IDLE && edge_det |=> state_q == ars_pkg::ARS_START)
		else $error("falling edge not taken");
	start_reject_a: assert property (SAMPLE_TICK && state_q == ars_pkg::ARS_START && slot_q == `ARS_SLOT_RT7
		&& low_total < `ARS_MIN_LOW_VOTES |=> state_q == ars_pkg::ARS_IDLE)
		else $error("noise start accepted");
	fe_block_a: assert property (st_q.framing && !clr |=> $stable(RX_DATA) && !$rose(st_q.full))
		else $error("transfer while framing flag set");
	preload_hist_a: assert property (done && !maj && !is_break |=> hist_q == `ARS_HIST_IDLE)
		else $error("edge history not preloaded");
	noise_set_a: assert property (load && frame_noise |=> st_q.noise)
		else $error("noise flag missed");
	realign_a: assert property (in_bits && edge_det |=> slot_q == 4'h1)
		else $error("slot timing not realigned");
	fe_set_a: assert property (accept && !maj |=> st_q.framing)
		else $error("framing flag missed");

	char_loaded_c: cover property (load);
	overrun_c: cover property (accept && st_q.full);
	framing_c: cover property (accept && !maj);
	noisy_c: cover property (load && frame_noise);
endmodule

// ==== ars_params.svh ====
// constants of the asynchronous serial receive sampler
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH
`define ARS_DATA_BITS_STD 4'h8
`define ARS_DATA_BITS_ALT 4'h9
`define ARS_SLOT_RT3 4'h2
`define ARS_SLOT_RT5 4'h4
`define ARS_SLOT_RT7 4'h6
`define ARS_SLOT_RT8 4'h7
`define ARS_SLOT_RT9 4'h8
`define ARS_SLOT_RT10 4'h9
`define ARS_SLOT_RT16 4'hF
`define ARS_HIST_IDLE 3'h7
`define ARS_MIN_LOW_VOTES 2'h2
`define ARS_WORD_RESET 9'h000
`endif

// ==== ars_pkg.sv ====
// types shared by the asynchronous serial receive sampler
package ars_pkg;
	typedef enum logic [1:0]
	{
		ARS_IDLE = 2'b00,
		ARS_START = 2'b01,
		ARS_BITS = 2'b10
	} ars_state_t;

	typedef struct packed
	{
		logic full;
		logic overrun;
		logic noise;
		logic framing;
	} ars_status_t;
endpackage

// ==== ars_rx_buffer.sv ====
// receive data register written when a character is moved out of the shifter
`timescale 1ns/100ps
`include "ars_params.svh"
module ars_rx_buffer #(
	parameter int W = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata
);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= W'(`ARS_WORD_RESET);
		else if (load)
			rdata <= wdata;
	end
endmodule

// ==== ars_tx_model.sv ====
// behavioural far-end transmitter that drives the serial line
`timescale 1ns/100ps
module ars_tx_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic go,
	input wire logic [10:0] frame,
	input wire logic [7:0] ticks,
	input wire logic glitch,
	output logic line,
	output logic busy
);
	logic [10:0] sh_q;
	logic [7:0] cnt_q;
	assign busy = cnt_q != 8'h00;
	// idle high, start, data lsb first, stop
	// a glitch only lifts low bits, so it never makes a false falling edge
	assign line = !busy | (sh_q[0] ^ (glitch & !sh_q[0] & cnt_q[3:0] == 4'h8));
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 8'h00;
		else if (go)
		begin
			sh_q <= frame;
			cnt_q <= ticks;
		end
		else if (tick && busy)
		begin
			cnt_q <= cnt_q - 8'h01;
			if (cnt_q[3:0] == 4'h1)
				sh_q <= sh_q >> 1;
		end
	end
endmodule

// ==== tb.sv ====
// self-checking bench for the asynchronous serial receive sampler
`timescale 1ns/100ps
module tb;
	logic clk, rst_n, tick, go, glitch, spike, d9, wake, srd, drd, line, busy, standby;
	logic [10:0] frame;
	logic [7:0] ticks;
	logic [8:0] rx_data;
	ars_pkg::ars_status_t rx_status;
	int miscompares = 0;
	int n_checks = 0;
	ars_receiver u_ars_receiver (.CLK(clk), .RST_N(rst_n), .SAMPLE_TICK(tick), .RXD_IN(line & !spike),
		.DATA9_SEL(d9), .WAKE_REQ(wake), .STATUS_RD(srd), .DATA_RD(drd), .RX_DATA(rx_data),
		.RX_STATUS(rx_status), .RX_STANDBY(standby));
	ars_tx_model u_ars_tx_model (.clk(clk), .rst_n(rst_n), .tick(tick), .go(go), .frame(frame),
		.ticks(ticks), .glitch(glitch), .line(line), .busy(busy));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// tick every second cycle keeps a frame short
	always @(negedge clk)
		tick <= rst_n ? ~tick : 1'b0;
	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [8:0] d, input logic stop_v, input logic g);
		@(negedge clk);
		go = 1'b1;
		glitch = g;
		frame = d9 ? {stop_v, d, 1'b0} : {1'b1, stop_v, d[7:0], 1'b0};
		ticks = d9 ? 8'hB0 : 8'hA0;
		@(negedge clk);
		go = 1'b0;
		repeat (400) if (busy === 1'b1) @(negedge clk);
		chk({8'h00, busy}, 9'h000);
		repeat (8) @(negedge clk);
	endtask
	task automatic clear();
		@(negedge clk);
		srd = 1'b1;
		@(negedge clk);
		srd = 1'b0;
		drd = 1'b1;
		@(negedge clk);
		drd = 1'b0;
		@(negedge clk);
	endtask
	initial
	begin
		{rst_n, go, glitch, spike, d9, wake, srd, drd} = 8'h00;
		frame = 11'h7FF;
		ticks = 8'h00;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		chk({5'h00, rx_status}, 9'h000);
		send(9'h0A5, 1'b1, 1'b0);
		chk(rx_data, 9'h0A5);
		chk({5'h00, rx_status}, 9'h008);
		send(9'h03C, 1'b1, 1'b0);
		chk(rx_data, 9'h0A5);
		chk({5'h00, rx_status}, 9'h00C);
		clear();
		chk({5'h00, rx_status}, 9'h000);
		d9 = 1'b1;
		send(9'h1A5, 1'b1, 1'b0);
		chk(rx_data, 9'h1A5);
		clear();
		d9 = 1'b0;
		send(9'h055, 1'b1, 1'b1);
		chk(rx_data, 9'h055);
		chk({5'h00, rx_status}, 9'h00A);
		clear();
		send(9'h081, 1'b0, 1'b0);
		chk({5'h00, rx_status}, 9'h009);
		// the low stop retriggers a start at once; let that all-ones frame run out unloaded
		repeat (320) @(negedge clk);
		send(9'h042, 1'b1, 1'b0);
		chk(rx_data, 9'h081);
		chk({5'h00, rx_status}, 9'h009);
		clear();
		// flags cleared early, so the retriggered frame lands as all ones with noise
		send(9'h081, 1'b0, 1'b0);
		clear();
		repeat (320) @(negedge clk);
		chk(rx_data, 9'h0FF);
		chk({5'h00, rx_status}, 9'h00A);
		clear();
		// one low sample must not pass the start check
		spike = 1'b1;
		repeat (2) @(negedge clk);
		spike = 1'b0;
		repeat (400) @(negedge clk);
		chk({5'h00, rx_status}, 9'h000);
		wake = 1'b1;
		@(negedge clk);
		wake = 1'b0;
		@(negedge clk);
		chk({8'h00, standby}, 9'h001);
		send(9'h011, 1'b1, 1'b0);
		chk({5'h00, rx_status}, 9'h000);
		send(9'h091, 1'b1, 1'b0);
		chk({8'h00, standby}, 9'h000);
		chk({5'h00, rx_status}, 9'h000);
		report_and_stop();
	end
	initial
	begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule
